/* logic/gpio_port_b_change_irq.sv */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - direction bit 1 floats the pin, 0 drives the output latch
// - latch register reads back latched value, not pin levels
// - port register read gives pin levels, write updates the latch
// - one active-low bit 7 of edge control enables all pull-ups
// - pull-up off on any pin configured as output
// - pull-ups disabled after power-on reset
// - change detection only on pins 7:4 configured as inputs
// - upper input pins compared with value captured at last port access
// - mismatches ORed set the change flag at bit 0 of main control
// - change interrupt can wake the device
// - port read or write recaptures, except file-to-file move destination
// - mismatch keeps setting flag; clearable one cycle after port access
// - on 80-pin parts outside default mode select bit routes compare unit two to pin 3
// - routed compare output overrides latch on output, capture on input
// - pins 0-3 feed external interrupts, pins 4-7 change inputs
// - programming mode makes pin 6 clock in, pin 7 data, their pull-ups and change detection off
module gpio_port_b_change_irq #(
	parameter bit PIN80 = 1'b1
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic [port_pin_levels_pkg::ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic FILE_MOVE_DEST,
	output logic [7:0] RDATA,
	input wire logic [7:0] PIN_IN,
	output logic [7:0] PIN_OUT,
	output logic [7:0] PIN_OE,
	output logic [7:0] PIN_PULLUP,
	input wire logic CAPTURE_COMPARE_TWO_OUT,
	input wire logic CAPTURE_COMPARE_TWO_OUT_EN,
	output logic CAPTURE_COMPARE_TWO_CAPTURE,
	output logic [3:0] EXT_IRQ,
	output logic PROG_CLOCK_IN,
	output logic PROG_DATA_IN,
	input wire logic PROG_DATA_OUT,
	input wire logic PROG_DATA_OE,
	output logic PORT_CHANGE_IRQ,
	output logic PORT_CHANGE_PRIO,
	output logic WAKE_REQ
);
	// ****************************************
	// elaboration checks
	// ****************************************
	if (port_pin_levels_pkg::CHG_LO + port_pin_levels_pkg::CHG_W != 8) begin : g_bad
		$error("gpio_port_b_change_irq: change pins must be the upper nibble");
	end

	// address match helper
	function automatic logic hit(
		input logic [port_pin_levels_pkg::ADDR_W-1:0] a,
		input logic [port_pin_levels_pkg::ADDR_W-1:0] off
	);
		hit = (a == off);
	endfunction : hit

	// ****************************************
	// declarations
	// ****************************************
	logic [7:0] pins_sync;
	logic [7:0] latch_r;
	logic [7:0] dir_r;
	logic [7:0] icmain_r;
	logic [7:0] icedge_r;
	logic [7:0] icext_r;
	logic [7:0] cfg_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] pin_out_r;
	logic [7:0] pin_out_nxt;
	logic [7:0] pin_oe_r;
	logic [7:0] pin_oe_nxt;
	logic [7:0] pullup_r;
	logic [7:0] pullup_nxt;
	logic [3:0] ext_irq_r;
	logic ccp_cap_r;
	logic prog_clk_r;
	logic prog_dat_r;
	logic irq_r;
	logic prio_r;
	logic wake_r;
	logic flag_nxt;
	logic port_access;
	logic mismatch;
	logic ccp_routed;
	logic prog_en;
	logic pullup_disable_n;
	logic port_change_flag;
	logic port_change_enable;
	logic [port_pin_levels_pkg::CHG_W-1:0] chg_is_input;

	// ****************************************
	// input synchronisation
	// ****************************************
	// pins pass two flops before use
	pin_sync #(
		.WIDTH(8),
		.STAGES(port_pin_levels_pkg::SYNC_STAGES)
	) u_sync (
		.clock(CLOCK),
		.reset(RESET),
		.async_in(PIN_IN),
		.sync_out(pins_sync)
	);

	// ****************************************
	// decoded controls
	// ****************************************
	assign prog_en = cfg_r[port_pin_levels_pkg::CFG_PROG_BIT];
	assign pullup_disable_n = icedge_r[port_pin_levels_pkg::PULLUP_N_BIT];
	assign port_change_flag = icmain_r[port_pin_levels_pkg::FLAG_BIT];
	assign port_change_enable = icmain_r[port_pin_levels_pkg::ENABLE_BIT];

	// alternate route only on 80-pin parts outside default mode
	assign ccp_routed = PIN80 && !cfg_r[port_pin_levels_pkg::CFG_SEL_BIT]
		&& !cfg_r[port_pin_levels_pkg::CFG_MCU_BIT];

	// any port access recaptures unless move destination
	assign port_access = (RD && hit(ADDR, port_pin_levels_pkg::OFF_PINS))
		|| (WR && hit(ADDR, port_pin_levels_pkg::OFF_PINS) && !FILE_MOVE_DEST);

	// ****************************************
	// change detection
	// ****************************************
	// only upper inputs compared, programming pins excluded
	always_comb begin
		chg_is_input = dir_r[7:port_pin_levels_pkg::CHG_LO];
		if (prog_en) begin
			chg_is_input[port_pin_levels_pkg::PCLK_PIN - port_pin_levels_pkg::CHG_LO] = 1'b0;
			chg_is_input[port_pin_levels_pkg::PDAT_PIN - port_pin_levels_pkg::CHG_LO] = 1'b0;
		end
	end

	// compare upper pins against last captured copy
	change_detect #(
		.WIDTH(port_pin_levels_pkg::CHG_W)
	) u_change (
		.clock(CLOCK),
		.reset(RESET),
		.level(pins_sync[7:port_pin_levels_pkg::CHG_LO]),
		.is_input(chg_is_input),
		.recapture(port_access),
		.mismatch(mismatch)
	);

	// ****************************************
	// output latch and direction
	// ****************************************
	// port write and latch write both load the latch
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			latch_r <= port_pin_levels_pkg::RST_LATCH;
		end else if (WR && (hit(ADDR, port_pin_levels_pkg::OFF_PINS)
				|| hit(ADDR, port_pin_levels_pkg::OFF_LATCH))) begin
			latch_r <= WDATA;
		end
	end

	// direction register, all inputs after reset
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			dir_r <= port_pin_levels_pkg::RST_DIR;
		end else if (WR && hit(ADDR, port_pin_levels_pkg::OFF_DIR)) begin
			dir_r <= WDATA;
		end
	end

	// ****************************************
	// interrupt control registers
	// ****************************************
	// mismatch sets flag, set wins over clear
	always_comb begin
		flag_nxt = port_change_flag;
		if (WR && hit(ADDR, port_pin_levels_pkg::OFF_ICMAIN)) begin
			flag_nxt = WDATA[port_pin_levels_pkg::FLAG_BIT];
		end
		if (mismatch) begin
			flag_nxt = 1'b1;
		end
	end

	// main control, flag bit owned by hardware set logic
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			icmain_r <= port_pin_levels_pkg::RST_ICMAIN;
		end else begin
			if (WR && hit(ADDR, port_pin_levels_pkg::OFF_ICMAIN)) begin
				icmain_r <= WDATA;
			end
			icmain_r[port_pin_levels_pkg::FLAG_BIT] <= flag_nxt;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			icedge_r <= port_pin_levels_pkg::RST_ICEDGE;
		end else if (WR && hit(ADDR, port_pin_levels_pkg::OFF_ICEDGE)) begin
			icedge_r <= WDATA;
		end
	end

	// external interrupt control, stored only
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			icext_r <= port_pin_levels_pkg::RST_ICEXT;
		end else if (WR && hit(ADDR, port_pin_levels_pkg::OFF_ICEXT)) begin
			icext_r <= WDATA;
		end
	end

	// configuration: pin select, default mode, programming enable
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			cfg_r <= port_pin_levels_pkg::RST_CFG;
		end else if (WR && hit(ADDR, port_pin_levels_pkg::OFF_CFG)) begin
			cfg_r <= WDATA & port_pin_levels_pkg::CFG_MASK;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	// port read shows pins, latch read shows latch
	always_comb begin
		case (ADDR)
			port_pin_levels_pkg::OFF_PINS: rdata_nxt = pins_sync;
			port_pin_levels_pkg::OFF_LATCH: rdata_nxt = latch_r;
			port_pin_levels_pkg::OFF_DIR: rdata_nxt = dir_r;
			port_pin_levels_pkg::OFF_ICMAIN: rdata_nxt = icmain_r;
			port_pin_levels_pkg::OFF_ICEDGE: rdata_nxt = icedge_r;
			port_pin_levels_pkg::OFF_ICEXT: rdata_nxt = icext_r;
			port_pin_levels_pkg::OFF_CFG: rdata_nxt = cfg_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			rdata_r <= 8'h00;
		end else if (RD) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	// direction picks float or latch drive
	always_comb begin
		pin_out_nxt = latch_r;
		pin_oe_nxt = ~dir_r;
		// compare output overrides latch on pin 3
		if (ccp_routed && !dir_r[port_pin_levels_pkg::CCP_PIN] && CAPTURE_COMPARE_TWO_OUT_EN) begin
			pin_out_nxt[port_pin_levels_pkg::CCP_PIN] = CAPTURE_COMPARE_TWO_OUT;
		end
		if (prog_en) begin
			pin_out_nxt[port_pin_levels_pkg::PCLK_PIN] = 1'b0;
			pin_oe_nxt[port_pin_levels_pkg::PCLK_PIN] = 1'b0;
			pin_out_nxt[port_pin_levels_pkg::PDAT_PIN] = PROG_DATA_OUT;
			pin_oe_nxt[port_pin_levels_pkg::PDAT_PIN] = PROG_DATA_OE;
		end
	end

	// pull-ups on when control bit low, inputs only
	always_comb begin
		pullup_nxt = {8{~pullup_disable_n}} & dir_r;
		if (prog_en) begin
			pullup_nxt[port_pin_levels_pkg::PCLK_PIN] = 1'b0;
			pullup_nxt[port_pin_levels_pkg::PDAT_PIN] = 1'b0;
		end
	end

	// registered pin outputs
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			pin_out_r <= 8'h00;
			pin_oe_r <= 8'h00;
			pullup_r <= 8'h00;
		end else begin
			pin_out_r <= pin_out_nxt;
			pin_oe_r <= pin_oe_nxt;
			pullup_r <= pullup_nxt;
		end
	end

	// ****************************************
	// peripheral inputs
	// ****************************************
	// low pins feed external interrupts when inputs
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ext_irq_r <= 4'h0;
		end else begin
			ext_irq_r <= pins_sync[3:0] & dir_r[3:0];
		end
	end

	// pin 3 is capture input when routed and input
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ccp_cap_r <= 1'b0;
		end else begin
			ccp_cap_r <= ccp_routed && dir_r[port_pin_levels_pkg::CCP_PIN]
				&& pins_sync[port_pin_levels_pkg::CCP_PIN];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			prog_clk_r <= 1'b0;
			prog_dat_r <= 1'b0;
		end else begin
			prog_clk_r <= prog_en && pins_sync[port_pin_levels_pkg::PCLK_PIN];
			prog_dat_r <= prog_en && pins_sync[port_pin_levels_pkg::PDAT_PIN];
		end
	end

	// ****************************************
	// interrupt request and wake
	// ****************************************
	// enabled flag requests interrupt and wake
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			irq_r <= 1'b0;
			prio_r <= 1'b0;
			wake_r <= 1'b0;
		end else begin
			irq_r <= port_change_flag && port_change_enable;
			prio_r <= icedge_r[port_pin_levels_pkg::PRIO_BIT];
			wake_r <= port_change_flag && port_change_enable;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign RDATA = rdata_r;
	assign PIN_OUT = pin_out_r;
	assign PIN_OE = pin_oe_r;
	assign PIN_PULLUP = pullup_r;
	assign EXT_IRQ = ext_irq_r;
	assign CAPTURE_COMPARE_TWO_CAPTURE = ccp_cap_r;
	assign PROG_CLOCK_IN = prog_clk_r;
	assign PROG_DATA_IN = prog_dat_r;
	assign PORT_CHANGE_IRQ = irq_r;
	assign PORT_CHANGE_PRIO = prio_r;
	assign WAKE_REQ = wake_r;
endmodule : gpio_port_b_change_irq
`default_nettype wire

/* logic/port_pin_levels_pkg.sv */
`default_nettype none
package port_pin_levels_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFF_PINS = 3'h0;
	localparam logic [2:0] OFF_LATCH = 3'h1;
	localparam logic [2:0] OFF_DIR = 3'h2;
	localparam logic [2:0] OFF_ICMAIN = 3'h3;
	localparam logic [2:0] OFF_ICEDGE = 3'h4;
	localparam logic [2:0] OFF_ICEXT = 3'h5;
	localparam logic [2:0] OFF_CFG = 3'h6;

	// ****************************************
	// field positions
	// ****************************************
	localparam int FLAG_BIT = 0;
	localparam int ENABLE_BIT = 3;
	localparam int PRIO_BIT = 0;
	localparam int PULLUP_N_BIT = 7;
	localparam int CFG_SEL_BIT = 0;
	localparam int CFG_MCU_BIT = 1;
	localparam int CFG_PROG_BIT = 2;
	localparam logic [7:0] CFG_MASK = 8'h07;

	// ****************************************
	// pin roles
	// ****************************************
	localparam int CCP_PIN = 3;
	localparam int PCLK_PIN = 6;
	localparam int PDAT_PIN = 7;
	localparam int CHG_LO = 4;
	localparam int CHG_W = 4;
	localparam int SYNC_STAGES = 2;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_DIR = 8'hff;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_ICMAIN = 8'h00;
	localparam logic [7:0] RST_ICEDGE = 8'hff;
	localparam logic [7:0] RST_ICEXT = 8'h00;
	localparam logic [7:0] RST_CFG = 8'h03;
endpackage : port_pin_levels_pkg
`default_nettype wire

/* logic/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8,
	parameter int STAGES = 2
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// ****************************************
	// elaboration checks
	// ****************************************
	if (WIDTH < 1 || STAGES != 2) begin : g_bad
		$error("pin_sync: WIDTH must be positive and STAGES two");
	end

	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stable_r;

	// two flops, first one read only by the second
	always_ff @(posedge clock) begin
		if (reset) begin
			meta_r <= '0;
			stable_r <= '0;
		end else begin
			meta_r <= async_in;
			stable_r <= meta_r;
		end
	end

	assign sync_out = stable_r;
endmodule : pin_sync
`default_nettype wire

/* logic/change_detect.sv */
`timescale 1ns/1ns
`default_nettype none
module change_detect #(
	parameter int WIDTH = 4
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] level,
	input wire logic [WIDTH-1:0] is_input,
	input wire logic recapture,
	output logic mismatch
);
	if (WIDTH < 1) begin : g_bad
		$error("change_detect: WIDTH must be positive");
	end

	logic [WIDTH-1:0] snap_r;
	logic mismatch_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			snap_r <= '0;
		end else if (recapture) begin
			snap_r <= level;
		end
	end

	// outputs masked out, access ends mismatch
	always_ff @(posedge clock) begin
		if (reset) begin
			mismatch_r <= 1'b0;
		end else if (recapture) begin
			mismatch_r <= 1'b0;
		end else begin
			mismatch_r <= |((level ^ snap_r) & is_input);
		end
	end

	assign mismatch = mismatch_r;
endmodule : change_detect
`default_nettype wire

/* verification/pin_world.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// pins seen from outside
// ********
module pin_world (
	input wire logic clock,
	input wire logic [7:0] drv,
	input wire logic [7:0] oe,
	input wire logic [7:0] pull,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] level
);
	logic [7:0] wob = 8'h00;
	// undriven pins without pull-up wander
	always @(posedge clock) wob <= ~wob;
	// device drive, then outside drive, then pull-up
	always_comb level = (oe & drv) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull | wob));
endmodule : pin_world
`default_nettype wire

/* verification/port_b_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ********
// port checker
// ********
module port_b_monitor (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic [port_pin_levels_pkg::ADDR_W-1:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic [7:0] PIN_IN,
	input wire logic [7:0] PIN_OE,
	input wire logic [7:0] PIN_PULLUP,
	input wire logic [3:0] EXT_IRQ,
	input wire logic PORT_CHANGE_IRQ,
	input wire logic WAKE_REQ
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);
	property p_dir_oe;
		WR && ADDR == 3'h2 ##1 !(WR && ADDR == 3'h2) |=> PIN_OE[5:0] == ~$past(WDATA[5:0], 2);
	endproperty
	a_dir_oe: assert property (p_dir_oe) else $error("enable off direction");
	property p_latch_rd;
		WR && ADDR == 3'h1 ##1 !WR ##1 RD && ADDR == 3'h1 |=> RDATA == $past(WDATA, 3);
	endproperty
	a_latch_rd: assert property (p_latch_rd) else $error("latch readback");
	property p_rd_idle;
		!RD |=> RDATA == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
	property p_pull_off;
		WR && ADDR == 3'h4 && WDATA[7] |=> ##1 PIN_PULLUP == 8'h00;
	endproperty
	a_pull_off: assert property (p_pull_off) else $error("pull-up not off");
	property p_pull_out;
		(PIN_PULLUP[5:0] & PIN_OE[5:0]) == 6'h00;
	endproperty
	a_pull_out: assert property (p_pull_out) else $error("pull-up on output");
	property p_pull_rst;
		$fell(RESET) |-> PIN_PULLUP == 8'h00;
	endproperty
	a_pull_rst: assert property (p_pull_rst) else $error("pull-up after reset");
	property p_wake;
		WAKE_REQ == PORT_CHANGE_IRQ;
	endproperty
	a_wake: assert property (p_wake) else $error("wake differs");
	property p_ext;
		(EXT_IRQ & PIN_OE[3:0]) == 4'h0;
	endproperty
	a_ext: assert property (p_ext) else $error("ext irq on output");
	// port read, one idle cycle, flag clear, with pins quiet before the read
	property p_clear;
		RD && ADDR == 3'h0 && $past(PIN_IN) == $past(PIN_IN, 2) ##1 !WR
			##1 WR && ADDR == 3'h3 && !WDATA[0] |=> ##1 !PORT_CHANGE_IRQ;
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
	c_irq: cover property ($rose(PORT_CHANGE_IRQ));
	c_pull: cover property (PIN_PULLUP != 8'h00);
	c_clr: cover property (RD && ADDR == 3'h0 ##2 WR && ADDR == 3'h3);
endmodule : port_b_monitor
bind gpio_port_b_change_irq port_b_monitor i_port_b_monitor (
	.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .PIN_IN(PIN_IN), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP),
	.EXT_IRQ(EXT_IRQ), .PORT_CHANGE_IRQ(PORT_CHANGE_IRQ), .WAKE_REQ(WAKE_REQ)
);
`default_nettype wire

/* verification/gpio_port_b_change_irq_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module gpio_port_b_change_irq_tb_top;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic fmd = 1'b0;
	logic ccp_out = 1'b0;
	logic ccp_en = 1'b0;
	logic pd_out = 1'b0;
	logic pd_oe = 1'b0;
	logic [7:0] ext_val = 8'h00;
	logic [7:0] ext_en = 8'hff;
	logic [7:0] rdata, pin_in, pin_out, pin_oe, pin_pull;
	logic [3:0] ext_irq;
	logic ccp_cap, pclk, pd_in, irq, prio, wake;
	logic [7:0] rst [8] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h03, 8'h00};
	logic [7:0] ext, v, m, d;
	int n_mismatch = 0;
	int compares = 0;
	// clock
	always #2 clock = ~clock;
	gpio_port_b_change_irq i_gpio_port_b_change_irq (
		.CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
		.FILE_MOVE_DEST(fmd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
		.PIN_OE(pin_oe), .PIN_PULLUP(pin_pull), .CAPTURE_COMPARE_TWO_OUT(ccp_out), .CAPTURE_COMPARE_TWO_OUT_EN(ccp_en),
		.CAPTURE_COMPARE_TWO_CAPTURE(ccp_cap), .EXT_IRQ(ext_irq), .PROG_CLOCK_IN(pclk),
		.PROG_DATA_IN(pd_in), .PROG_DATA_OUT(pd_out), .PROG_DATA_OE(pd_oe),
		.PORT_CHANGE_IRQ(irq), .PORT_CHANGE_PRIO(prio), .WAKE_REQ(wake)
	);
	pin_world i_pin_world (
		.clock(clock), .drv(pin_out), .oe(pin_oe), .pull(pin_pull),
		.ext_val(ext_val), .ext_en(ext_en), .level(pin_in)
	);
	task finish_test;
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one write strobe, then an idle cycle
	task wr(input logic [2:0] a, input logic [7:0] x);
		addr <= a;
		wdata <= x;
		wr_s <= 1'b1;
		@(posedge clock);
		wr_s <= 1'b0;
		@(posedge clock);
	endtask : wr
	// data stands in the cycle after the strobe
	task rd(input logic [2:0] a, output logic [7:0] x);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clock);
		rd_s <= 1'b0;
		@(posedge clock);
		x = rdata;
	endtask : rd
	// wait on the request line, never poll the port
	task wait_irq;
		for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clock);
	endtask : wait_irq
	// hang guard
	initial begin
		repeat (3000) @(posedge clock);
		n_mismatch++;
		finish_test();
	end
	// main sequence
	initial begin
		v = 8'($urandom(32'hda9c96d2));
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		wr(3'h7, 8'h5a);
		for (int a = 1; a < 8; a++) begin
			rd(3'(a), d);
			chk("reset reg", rst[a], d);
		end
		chk("pull", 8'h00, pin_pull);
		ext = 8'($urandom);
		ext_val <= ext;
		for (int k = 0; k < 4; k++) begin
			v = 8'($urandom);
			m = 8'($urandom);
			wr(3'h2, m);
			wr(k[0] ? 3'h1 : 3'h0, v);
			rd(3'h1, d);
			chk("latch", v, d);
			repeat (3) @(posedge clock);
			rd(3'h0, d);
			chk("pins", (v & ~m) | (ext & m), d);
			chk("oe", ~m, pin_oe);
			chk("out", v & ~m, pin_out & ~m);
			chk("ext irq", {4'h0, ext[3:0] & m[3:0]}, {4'h0, ext_irq});
		end
		wr(3'h2, 8'hf1);
		wr(3'h4, 8'h7e);
		ext_en <= 8'hfe;
		repeat (4) @(posedge clock);
		chk("pull on", 8'hf1, pin_pull);
		chk("prio low", 8'h00, {7'h0, prio});
		rd(3'h0, d);
		chk("pulled pin", (v & 8'h0e) | (ext & 8'hf0) | 8'h01, d);
		wr(3'h4, 8'hff);
		ext_en <= 8'hff;
		repeat (3) @(posedge clock);
		chk("pull off", 8'h00, pin_pull);
		chk("prio high", 8'h01, {7'h0, prio});
		wr(3'h3, 8'h08);
		rd(3'h0, d);
		wr(3'h3, 8'h08);
		repeat (3) @(posedge clock);
		chk("irq idle", 8'h00, {7'h0, irq});
		ext ^= 8'h20;
		ext_val <= ext;
		wait_irq();
		chk("irq set", 8'h01, {7'h0, irq});
		chk("wake", 8'h01, {7'h0, wake});
		fmd <= 1'b1;
		wr(3'h0, v);
		fmd <= 1'b0;
		wr(3'h3, 8'h08);
		repeat (3) @(posedge clock);
		chk("irq held", 8'h01, {7'h0, irq});
		// port read, one idle cycle, then flag clear
		rd(3'h0, d);
		wr(3'h3, 8'h08);
		repeat (3) @(posedge clock);
		chk("irq clear", 8'h00, {7'h0, irq});
		wr(3'h2, 8'hef);
		wr(3'h1, v ^ 8'h10);
		ext ^= 8'h1a;
		ext_val <= ext;
		repeat (8) @(posedge clock);
		chk("irq masked", 8'h00, {7'h0, irq});
		wr(3'h6, 8'h00);
		wr(3'h2, 8'hf7);
		ccp_en <= 1'b1;
		ccp_out <= ~v[3];
		repeat (3) @(posedge clock);
		chk("ccp drive", {7'h0, ~v[3]}, {7'h0, pin_out[3]});
		// capture pin high so the unrouted check can trip
		ext[3] = 1'b1;
		ext_val <= ext;
		wr(3'h2, 8'hff);
		repeat (4) @(posedge clock);
		chk("ccp capture", {7'h0, ext[3]}, {7'h0, ccp_cap});
		wr(3'h6, 8'h02);
		repeat (3) @(posedge clock);
		chk("ccp unrouted", 8'h00, {7'h0, ccp_cap});
		wr(3'h6, 8'h07);
		pd_oe <= 1'b1;
		pd_out <= ~ext[7];
		repeat (6) @(posedge clock);
		chk("prog", {4'h0, 1'b1, ~ext[7], ext[6], ~ext[7]},
			{4'h0, pin_oe[7], pin_out[7], pclk, pd_in});
		finish_test();
	end
endmodule : gpio_port_b_change_irq_tb_top
`default_nettype wire
